// file: hdl/flash_sr_pkg.sv
// Shared constants, types and helpers for the flash suspend/resume link.
package flash_sr_pkg;
  localparam int ADDR_W = 26;
  localparam int OP_CNT_W = 24;
  localparam int SECT_LSB = 18;
  localparam int PAGE_LSB = 9;
  localparam int CLK_NS = 5;
  localparam int ERS_LAT_NS = 48000;
  localparam int PGM_LAT_NS = 40000;
  localparam int RES_GAP_NS = 128000;
  // Longest times round down, least times round up.
  localparam int ERS_LAT_CYC = ERS_LAT_NS / CLK_NS;
  localparam int PGM_LAT_CYC = PGM_LAT_NS / CLK_NS;
  localparam int RES_GAP_CYC = (RES_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] SR_DWORD = 32'h4518_83EC;
  localparam logic [7:0] TBL_BASE = 8'h2C;
  localparam logic [7:0] TBL_LAST = 8'h2F;
  localparam logic [7:0] TBL_FILL = 8'hFF;
  localparam int SUP_BIT = 31;
  localparam int ERS_UNIT_LSB = 29;
  localparam int ERS_CNT_LSB = 24;
  localparam int PGM_UNIT_LSB = 18;
  localparam int PGM_CNT_LSB = 13;
  localparam int ERS_BAN_LSB = 4;
  localparam int PGM_BAN_LSB = 0;
  localparam int BAN_ERS_BIT = 0;
  localparam int BAN_PGM_BIT = 1;
  localparam int BAN_RD_BIT = 2;
  localparam logic [31:0] UNIT0_NS = 32'h0000_0080;
  localparam logic [31:0] UNIT1_NS = 32'h0000_03E8;
  localparam logic [31:0] UNIT2_NS = 32'h0000_1F40;
  localparam logic [31:0] UNIT3_NS = 32'h0000_FA00;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_PROG = 3'b010,
    OP_ERASE = 3'b011,
    OP_SUSPEND = 3'b100,
    OP_RESUME = 3'b101,
    OP_TBL_RD = 3'b110,
    OP_TBL_WR = 3'b111
  } op_e;

  // Cycles of a latency field: (count + 1) times the coded unit, rounded down.
  function automatic logic [31:0] lat_cycles(input logic [1:0] unit, input logic [4:0] cnt);
    logic [31:0] ns;
    case (unit)
      2'b00: ns = UNIT0_NS;
      2'b01: ns = UNIT1_NS;
      2'b10: ns = UNIT2_NS;
      default: ns = UNIT3_NS;
    endcase
    lat_cycles = ((32'(cnt) + 32'h1) * ns) / 32'(CLK_NS);
  endfunction
endpackage

// file: hdl/flash_sr_if.sv
// Link between the flash suspend/resume host and device ends.
`timescale 1ns/1ps
interface flash_sr_if
  import flash_sr_pkg::*;
(
  input wire logic MCLK // Shared clock.
);
  logic req;
  op_e op;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic rej;
  logic [7:0] rdata;
  logic busy;
  logic esusp;
  logic psusp;
  modport dev(input MCLK, req, op, addr, wdata, output ack, rej, rdata, busy, esusp, psusp);
  modport host(input MCLK, ack, rej, rdata, busy, esusp, psusp, output req, op, addr, wdata);
endinterface

// file: hdl/flash_sr_dev.sv
// Device end: erase/program sequencer with suspend/resume and table dword.
`timescale 1ns/1ps
module flash_sr_dev
  import flash_sr_pkg::*;
#(
  parameter int ERASE_CYC = 20000,
  parameter int PROG_CYC = 8000,
  parameter int SUSP_SETTLE = 64,
  parameter int ERS_LAT = ERS_LAT_CYC,
  parameter int PGM_LAT = PGM_LAT_CYC
) (
  input wire logic MCLK, // Clock.
  input wire logic SRST, // Synchronous reset, active high.
  flash_sr_if.dev LNK, // Link to the host.
  output logic BUSY, // Erase or program under way.
  output logic SUSPENDED // Erase or program suspended.
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ERASE = 3'b001,
    D_PROG = 3'b010,
    D_ESUSPING = 3'b011,
    D_PSUSPING = 3'b100,
    D_ESUSP = 3'b101,
    D_PSUSP = 3'b110
  } dstate_e;

  // Suspension lands at the settle time, never past the latency limit.
  localparam int ERS_STOP = (SUSP_SETTLE < ERS_LAT) ? SUSP_SETTLE : ERS_LAT - 1;
  localparam int PGM_STOP = (SUSP_SETTLE < PGM_LAT) ? SUSP_SETTLE : PGM_LAT - 1;
  localparam logic [OP_CNT_W-1:0] ERS_LIM = OP_CNT_W'(ERS_STOP);
  localparam logic [OP_CNT_W-1:0] PGM_LIM = OP_CNT_W'(PGM_STOP);
  localparam logic [OP_CNT_W-1:0] ERASE_W = OP_CNT_W'(ERASE_CYC);
  localparam logic [OP_CNT_W-1:0] PROG_W = OP_CNT_W'(PROG_CYC);
  localparam logic [OP_CNT_W-1:0] CNT_ONE = OP_CNT_W'(1);

  dstate_e st_q, st_d;
  logic [OP_CNT_W-1:0] work_q, work_d, lat_q, lat_d;
  logic ack_q, rej_q, busy_q, esusp_q, psusp_q, susp_q;
  logic [7:0] rdata_q;

  wire go_erase = LNK.req && (LNK.op == OP_ERASE);
  wire go_prog = LNK.req && (LNK.op == OP_PROG);
  wire go_susp = LNK.req && (LNK.op == OP_SUSPEND);
  wire go_res = LNK.req && (LNK.op == OP_RESUME);
  wire go_tbl = LNK.req && (LNK.op == OP_TBL_RD);
  wire go_read = LNK.req && (LNK.op == OP_READ);
  wire in_tbl = (LNK.addr[ADDR_W-1:8] == '0) && (LNK.addr[7:0] >= TBL_BASE)
    && (LNK.addr[7:0] <= TBL_LAST);
  wire [7:0] tbl_byte = 8'(SR_DWORD >> {LNK.addr[1:0], 3'b000});
  wire busy_d = (st_d != D_IDLE) && (st_d != D_ESUSP) && (st_d != D_PSUSP);

  always_comb begin
    st_d = st_q;
    work_d = work_q;
    lat_d = lat_q;
    case (st_q)
      D_IDLE: begin
        if (go_erase) begin
          st_d = D_ERASE;
          work_d = ERASE_W;
        end else if (go_prog) begin
          st_d = D_PROG;
          work_d = PROG_W;
        end
      end
      D_ERASE, D_PROG: begin
        if (work_q <= CNT_ONE) begin
          st_d = D_IDLE;
        end else begin
          work_d = work_q - CNT_ONE;
          lat_d = '0;
          if (go_susp) begin
            st_d = (st_q == D_ERASE) ? D_ESUSPING : D_PSUSPING;
          end
        end
      end
      D_ESUSPING: begin
        lat_d = lat_q + CNT_ONE;
        if (lat_q >= ERS_LIM) begin
          st_d = D_ESUSP;
        end
      end
      D_PSUSPING: begin
        lat_d = lat_q + CNT_ONE;
        if (lat_q >= PGM_LIM) begin
          st_d = D_PSUSP;
        end
      end
      D_ESUSP: begin
        if (go_res) begin
          st_d = D_ERASE;
        end
      end
      D_PSUSP: begin
        if (go_res) begin
          st_d = D_PROG;
        end
      end
      default: st_d = D_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_q <= D_IDLE;
      work_q <= '0;
      lat_q <= '0;
    end else begin
      st_q <= st_d;
      work_q <= work_d;
      lat_q <= lat_d;
    end
  end

  // Table writes are answered but never stored.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
      rej_q <= 1'b0;
      rdata_q <= TBL_FILL;
    end else begin
      ack_q <= LNK.req;
      rej_q <= LNK.req && (LNK.op == OP_TBL_WR);
      if (go_tbl) begin
        rdata_q <= in_tbl ? tbl_byte : TBL_FILL;
      end else if (go_read) begin
        rdata_q <= TBL_FILL;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      busy_q <= 1'b0;
      esusp_q <= 1'b0;
      psusp_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      esusp_q <= (st_d == D_ESUSP);
      psusp_q <= (st_d == D_PSUSP);
      susp_q <= (st_d == D_ESUSP) || (st_d == D_PSUSP);
    end
  end

  assign LNK.ack = ack_q;
  assign LNK.rej = rej_q;
  assign LNK.rdata = rdata_q;
  assign LNK.busy = busy_q;
  assign LNK.esusp = esusp_q;
  assign LNK.psusp = psusp_q;
  assign BUSY = busy_q;
  assign SUSPENDED = susp_q;
endmodule

// file: hdl/flash_sr_host.sv
// Host end: issues link commands and polices suspend/resume restrictions.
`timescale 1ns/1ps
module flash_sr_host
  import flash_sr_pkg::*;
#(
  parameter int RES_GAP = RES_GAP_CYC
) (
  input wire logic MCLK, // Clock.
  input wire logic SRST, // Synchronous reset, active high.
  flash_sr_if.host LNK, // Link to the device.
  input wire logic U_REQ, // User request strobe.
  input op_e U_OP, // User operation.
  input wire logic [ADDR_W-1:0] U_ADDR, // User address.
  input wire logic [7:0] U_WDATA, // User write byte.
  output logic U_ACK, // Request completed.
  output logic U_REJ, // Request refused or ignored.
  output logic [7:0] U_RDATA, // Returned byte.
  output logic U_READY, // Ready for a request.
  output logic U_TMO, // Suspend exceeded its latency.
  output logic [31:0] U_TABLE // Fetched table dword.
);
  typedef enum logic [1:0] {
    H_FETCH = 2'b00,
    H_FWAIT = 2'b01,
    H_READY = 2'b10,
    H_WAIT = 2'b11
  } hstate_e;

  localparam logic [OP_CNT_W-1:0] GAP_W = OP_CNT_W'(RES_GAP);
  localparam logic [OP_CNT_W-1:0] CNT_ONE = OP_CNT_W'(1);
  localparam logic [1:0] IDX_LAST = 2'b11;

  hstate_e st_q;
  logic [1:0] idx_q;
  logic [31:0] tbl_q;
  logic req_q;
  op_e op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wdata_q;
  logic ack_q, rej_q, ready_q, tmo_q, wd_on_q, kind_ers_q;
  logic [7:0] rdata_q;
  logic [OP_CNT_W-1:0] gap_q, wd_q;
  logic [ADDR_W-1:0] act_addr_q;

  wire [3:0] e_ban = tbl_q[ERS_BAN_LSB +: 4];
  wire [3:0] p_ban = tbl_q[PGM_BAN_LSB +: 4];
  wire same_sect = U_ADDR[ADDR_W-1:SECT_LSB] == act_addr_q[ADDR_W-1:SECT_LSB];
  wire same_page = U_ADDR[ADDR_W-1:PAGE_LSB] == act_addr_q[ADDR_W-1:PAGE_LSB];
  wire is_erase = U_OP == OP_ERASE;
  wire is_prog = U_OP == OP_PROG;
  wire is_read = U_OP == OP_READ;
  wire is_susp = U_OP == OP_SUSPEND;

  wire ban_er5 = LNK.esusp && is_erase && !e_ban[BAN_ERS_BIT];
  wire ban_er6 = LNK.esusp && is_prog && e_ban[BAN_PGM_BIT] && same_sect;
  wire ban_er7 = LNK.esusp && is_read && e_ban[BAN_RD_BIT] && same_sect;
  wire ban_pr8 = LNK.psusp && ((is_erase && !p_ban[BAN_ERS_BIT])
    || (is_prog && !p_ban[BAN_PGM_BIT]));
  wire ban_pr9 = LNK.psusp && is_read && p_ban[BAN_RD_BIT] && same_page;
  wire ban_busy = (is_erase || is_prog) && LNK.busy;
  wire ban_susp = is_susp && ((gap_q != '0) || !LNK.busy || tbl_q[SUP_BIT]);
  wire ban_res = (U_OP == OP_RESUME) && !(LNK.esusp || LNK.psusp);
  wire banned = ban_er5 || ban_er6 || ban_er7 || ban_pr8 || ban_pr9 || ban_busy
    || ban_susp || ban_res;
  wire take = U_REQ && (st_q == H_READY) && !banned;

  wire [31:0] ers_lat = lat_cycles(tbl_q[ERS_UNIT_LSB +: 2], tbl_q[ERS_CNT_LSB +: 5]);
  wire [31:0] pgm_lat = lat_cycles(tbl_q[PGM_UNIT_LSB +: 2], tbl_q[PGM_CNT_LSB +: 5]);
  wire [OP_CNT_W-1:0] wd_load = kind_ers_q ? OP_CNT_W'(ers_lat) : OP_CNT_W'(pgm_lat);
  wire resumed = LNK.ack && (st_q == H_WAIT) && (op_q == OP_RESUME);

  // Link request sequencing, including the table fetch after reset.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_q <= H_FETCH;
      idx_q <= 2'b00;
      req_q <= 1'b0;
      op_q <= OP_NONE;
      addr_q <= '0;
      wdata_q <= 8'h00;
    end else begin
      req_q <= 1'b0;
      case (st_q)
        H_FETCH: begin
          req_q <= 1'b1;
          op_q <= OP_TBL_RD;
          addr_q <= ADDR_W'({TBL_BASE[7:2], idx_q});
          st_q <= H_FWAIT;
        end
        H_FWAIT: begin
          if (LNK.ack) begin
            idx_q <= idx_q + 2'b01;
            st_q <= (idx_q == IDX_LAST) ? H_READY : H_FETCH;
          end
        end
        H_READY: begin
          if (take) begin
            req_q <= 1'b1;
            op_q <= U_OP;
            addr_q <= U_ADDR;
            wdata_q <= U_WDATA;
            st_q <= H_WAIT;
          end
        end
        default: begin
          if (LNK.ack) begin
            st_q <= H_READY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tbl_q <= '0;
    end else if ((st_q == H_FWAIT) && LNK.ack) begin
      tbl_q[{idx_q, 3'b000} +: 8] <= LNK.rdata;
    end
  end

  // User answers; a table write comes back refused because it is not stored.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
      rej_q <= 1'b0;
      rdata_q <= 8'h00;
      ready_q <= 1'b0;
    end else begin
      ack_q <= (st_q == H_WAIT) && LNK.ack;
      rej_q <= (U_REQ && !take) || ((st_q == H_WAIT) && LNK.ack && LNK.rej);
      ready_q <= (st_q == H_READY) && !take;
      if ((st_q == H_WAIT) && LNK.ack) begin
        rdata_q <= LNK.rdata;
      end
    end
  end

  // Tracks the operation that a later suspend would stop.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      act_addr_q <= '0;
      kind_ers_q <= 1'b0;
    end else if (take && (is_erase || is_prog) && !LNK.esusp) begin
      act_addr_q <= U_ADDR;
      kind_ers_q <= is_erase;
    end
  end

  // Holds off the next suspend after each resume.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      gap_q <= '0;
    end else if (resumed) begin
      gap_q <= GAP_W;
    end else if (gap_q != '0) begin
      gap_q <= gap_q - CNT_ONE;
    end
  end

  // Flags a suspend that outlasts the latency the table promises.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wd_on_q <= 1'b0;
      wd_q <= '0;
      tmo_q <= 1'b0;
    end else if (take && is_susp) begin
      wd_on_q <= 1'b1;
      wd_q <= wd_load + CNT_ONE;
    end else if (wd_on_q) begin
      if (LNK.esusp || LNK.psusp || (!LNK.busy && (st_q != H_WAIT))) begin
        wd_on_q <= 1'b0;
      end else if (wd_q == '0) begin
        wd_on_q <= 1'b0;
        tmo_q <= 1'b1;
      end else begin
        wd_q <= wd_q - CNT_ONE;
      end
    end
  end

  assign LNK.req = req_q;
  assign LNK.op = op_q;
  assign LNK.addr = addr_q;
  assign LNK.wdata = wdata_q;
  assign U_ACK = ack_q;
  assign U_REJ = rej_q;
  assign U_RDATA = rdata_q;
  assign U_READY = ready_q;
  assign U_TMO = tmo_q;
  assign U_TABLE = tbl_q;
endmodule

// file: bench/flash_sr_asserts.sv
// Concurrent checks on the link between the host and device ends.
`timescale 1ns/1ps
module flash_sr_asserts
  import flash_sr_pkg::*;
#(
  parameter int ERS_LAT = ERS_LAT_CYC,
  parameter int PGM_LAT = PGM_LAT_CYC,
  parameter int RES_GAP = RES_GAP_CYC
) (
  input wire logic MCLK, // Clock.
  input wire logic SRST, // Reset.
  input wire logic req, // Command valid.
  input op_e op, // Command.
  input wire logic [ADDR_W-1:0] addr, // Address.
  input wire logic ack, // Answer.
  input wire logic rej, // Refusal.
  input wire logic [7:0] rdata, // Read byte.
  input wire logic busy, // Running.
  input wire logic esusp, // Erase held.
  input wire logic psusp // Program held.
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  logic ers_q;
  logic pend_q;
  logic [15:0] cnt_q;
  logic [15:0] gap_q;
  logic [ADDR_W-1:0] at_q;
  op_e last_q;
  wire start = req && (op == OP_ERASE || op == OP_PROG) && !busy && !esusp && !psusp;
  wire in_tbl = addr >= ADDR_W'(TBL_BASE) && addr <= ADDR_W'(TBL_LAST);
  wire [7:0] exp_byte = in_tbl ? SR_DWORD[8*addr[1:0] +: 8] : TBL_FILL;
  wire held = esusp || psusp;
  // Cycle counts since a suspend request and since a resume answer.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ers_q <= 1'b0;
      at_q <= '0;
      pend_q <= 1'b0;
      cnt_q <= 16'h0000;
      gap_q <= 16'hFFFF;
      last_q <= OP_NONE;
    end else begin
      ers_q <= start ? (op == OP_ERASE) : ers_q;
      at_q <= start ? addr : at_q;
      pend_q <= (req && op == OP_SUSPEND && busy) || (pend_q && busy && !held);
      cnt_q <= pend_q ? cnt_q + 16'h0001 : 16'h0000;
      gap_q <= (ack && last_q == OP_RESUME) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
      last_q <= req ? op : last_q;
    end
  end
  a_ack_follows_req: assert property (req |=> ack)
    else $error("ack missing after req");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("ack without req");
  a_write_refused: assert property (req && op == OP_TBL_WR |=> ack && rej)
    else $error("table write not refused");
  a_rej_only_write: assert property (rej |-> $past(req && op == OP_TBL_WR))
    else $error("rej without table write");
  a_table_byte: assert property (req && op == OP_TBL_RD |=> rdata == $past(exp_byte))
    else $error("table byte wrong");
  a_erase_latency: assert property (pend_q && ers_q |-> 32'(cnt_q) < ERS_LAT)
    else $error("erase suspend too slow");
  a_prog_latency: assert property (pend_q && !ers_q |-> 32'(cnt_q) < PGM_LAT)
    else $error("program suspend too slow");
  a_resume_gap: assert property (req && op == OP_SUSPEND |-> 32'(gap_q) + 2 >= RES_GAP)
    else $error("suspend too soon after resume");
  a_no_nesting: assert property (req && held |-> op != OP_ERASE && !(psusp && op == OP_PROG))
    else $error("nested operation sent");
  a_sector_ban: assert property (req && esusp && (op == OP_PROG || op == OP_READ)
    |-> addr[ADDR_W-1:SECT_LSB] != at_q[ADDR_W-1:SECT_LSB])
    else $error("access to held sector");
  a_page_ban: assert property (req && psusp && op == OP_READ |-> addr[25:9] != at_q[25:9])
    else $error("read of held page");
  c_erase_held: cover property ($rose(esusp));
  c_prog_held: cover property ($rose(psusp));
  c_write_refused: cover property (rej);
endmodule

// file: bench/flash_suspend_resume_rules_bench.sv
// Self-checking bench joining the host and device ends of the flash link.
`timescale 1ns/1ps
module flash_suspend_resume_rules_bench;
  import flash_sr_pkg::*;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic U_REQ = 1'b0;
  op_e U_OP = OP_NONE;
  logic [ADDR_W-1:0] U_ADDR = '0;
  logic [7:0] U_WDATA = 8'h00;
  logic U_ACK, U_REJ, U_READY, U_TMO, BUSY, SUSPENDED;
  logic [7:0] U_RDATA;
  logic [31:0] U_TABLE;
  int num_errors = 0;
  int total_checks = 0;
  localparam logic [ADDR_W-1:0] SA = 26'h00C_0000;
  localparam logic [ADDR_W-1:0] PA = 26'h014_0200;
  localparam logic [31:0] UNIT[4] = '{32'h80, 32'h3E8, 32'h1F40, 32'hFA00};
  flash_sr_if u_flash_sr_if (.MCLK(MCLK));
  flash_sr_dev #(.ERASE_CYC(200), .PROG_CYC(100), .SUSP_SETTLE(8)) u_flash_sr_dev (
    .MCLK(MCLK), .SRST(SRST), .LNK(u_flash_sr_if.dev), .BUSY(BUSY), .SUSPENDED(SUSPENDED));
  flash_sr_host #(.RES_GAP(50)) u_flash_sr_host (.MCLK(MCLK), .SRST(SRST),
    .LNK(u_flash_sr_if.host), .U_REQ(U_REQ), .U_OP(U_OP), .U_ADDR(U_ADDR), .U_WDATA(U_WDATA),
    .U_ACK(U_ACK), .U_REJ(U_REJ), .U_RDATA(U_RDATA), .U_READY(U_READY), .U_TMO(U_TMO),
    .U_TABLE(U_TABLE));
  flash_sr_asserts #(.RES_GAP(50)) u_flash_sr_asserts (.MCLK(MCLK), .SRST(SRST),
    .req(u_flash_sr_if.req), .op(u_flash_sr_if.op), .addr(u_flash_sr_if.addr),
    .ack(u_flash_sr_if.ack), .rej(u_flash_sr_if.rej), .rdata(u_flash_sr_if.rdata),
    .busy(u_flash_sr_if.busy), .esusp(u_flash_sr_if.esusp), .psusp(u_flash_sr_if.psusp));
  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  // Exp bit 0 asks for U_ACK, bit 1 for U_REJ.
  task automatic go(input op_e o, input logic [ADDR_W-1:0] a, input logic [1:0] exp,
                    input logic rdy = 1'b1);
    int n;
    n = 0;
    while (rdy && U_READY !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (rdy) begin
      check("ready", 32'h1, 32'(U_READY));
    end
    @(posedge MCLK);
    U_REQ <= 1'b1;
    U_OP <= o;
    U_ADDR <= a;
    @(posedge MCLK);
    U_REQ <= 1'b0;
    #1;
    n = 0;
    while (U_ACK !== 1'b1 && U_REJ !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("ack", 32'(exp[0]), 32'(U_ACK));
    check("rej", 32'(exp[1]), 32'(U_REJ));
  endtask
  task automatic susp(input int lim, input logic ers);
    int n;
    n = 0;
    go(OP_SUSPEND, '0, 2'b01);
    while (SUSPENDED !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    check("latency", 32'h1, 32'(n + 3 <= lim));
    check("esusp", 32'(ers), 32'(u_flash_sr_if.esusp));
    check("psusp", 32'(!ers), 32'(u_flash_sr_if.psusp));
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (BUSY !== 1'b0 && n < 1000) begin
      tick(1);
      n++;
    end
    check("busy", 32'h0, 32'(BUSY));
  endtask
  function automatic logic [31:0] lat_ns(input logic [1:0] u, input logic [4:0] c);
    return (32'(c) + 32'h1) * UNIT[u];
  endfunction
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    num_errors++;
    results();
  end
  initial begin
    repeat (4) @(posedge MCLK);
    SRST <= 1'b0;
    go(OP_READ, '0, 2'b10, 1'b0);
    for (int i = 0; i < 4; i++) begin
      go(OP_TBL_RD, ADDR_W'(8'h2C + i), 2'b01);
      check("tbl_byte", 32'(8'(32'h4518_83EC >> (8 * i))), 32'(U_RDATA));
    end
    check("table", 32'h4518_83EC, U_TABLE);
    check("ers_lat", 32'h0000_BB80, lat_ns(U_TABLE[30:29], U_TABLE[28:24]));
    check("pgm_lat", 32'h0000_9C40, lat_ns(U_TABLE[19:18], U_TABLE[17:13]));
    go(OP_TBL_WR, 26'h000_002D, 2'b11);
    go(OP_TBL_RD, 26'h000_002D, 2'b01);
    check("tbl_kept", 32'h83, 32'(U_RDATA));
    go(OP_ERASE, SA, 2'b01);
    susp(ERS_LAT_CYC, 1'b1);
    go(OP_ERASE, '0, 2'b10);
    go(OP_PROG, SA + 26'h200, 2'b10);
    go(OP_READ, SA + 26'h3_0000, 2'b10);
    go(OP_READ, '0, 2'b01);
    go(OP_PROG, '0, 2'b01);
    go(OP_RESUME, '0, 2'b01);
    go(OP_SUSPEND, '0, 2'b10);
    tick(52);
    susp(ERS_LAT_CYC, 1'b1);
    go(OP_RESUME, '0, 2'b01);
    idle();
    go(OP_PROG, PA, 2'b01);
    susp(PGM_LAT_CYC, 1'b0);
    go(OP_ERASE, '0, 2'b10);
    go(OP_PROG, '0, 2'b10);
    go(OP_READ, PA + 26'h1F, 2'b10);
    go(OP_READ, PA + 26'h200, 2'b01);
    check("rdata", 32'hFF, 32'(U_RDATA));
    go(OP_RESUME, '0, 2'b01);
    go(OP_SUSPEND, '0, 2'b10);
    idle();
    go(OP_SUSPEND, '0, 2'b10);
    go(OP_RESUME, '0, 2'b10);
    check("tmo", 32'h0, 32'(U_TMO));
    // A reset in the middle of an erase must stop it and force a fresh table fetch.
    go(OP_ERASE, SA, 2'b01);
    @(posedge MCLK);
    SRST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SRST <= 1'b0;
    #1;
    check("busy_rst", 32'h0, 32'(BUSY));
    check("ready_rst", 32'h0, 32'(U_READY));
    check("table_rst", 32'h0, U_TABLE);
    go(OP_TBL_RD, 26'h000_002F, 2'b01);
    check("tbl_refetch", 32'h4518_83EC, U_TABLE);
    check("tbl_byte3", 32'h45, 32'(U_RDATA));
    results();
  end
endmodule
